// ---- ccp_pwm_top.sv ----
// PWM generator: two 8-bit timebases, two duty units and an Avalon-MM slave
//
// Behaviour
// - The period is (period limit + 1) times four oscillator clocks times a prescale of 1, 4 or 16.
// - When the count equals the period limit, the next increment clears the count.
// - That same increment sets the pin, unless the duty value loaded is zero.
// - That same increment copies the written duty byte and low bits into the active buffer.
// - The postscaler only makes a separate event rate and never changes the PWM period.
// - The duty is ten bits: the duty write byte on top and control bits 5:4 below.
// - The high time is the duty value times one oscillator clock times the prescale.
// - Duty writes land any time, act from the next period end, and the active byte is read-only in PWM.
// - The duty is double-buffered in the active byte plus a two-bit hidden latch.
// - The pin clears when the active duty equals the count extended by phase or prescaler bits.
// - A duty longer than the period never clears the pin, so it stays high.
// - Writing zero to the unit control register forces the unit's output latch low.
`default_nettype none

module ccp_pwm_top (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Avalon-MM register slave
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// PWM pins, index 0 is unit 4 and index 1 is unit 5
	output logic      [1:0]  pwm_output_pin,
	output logic      [1:0]  pin_claim
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pwm_pkg::bus_phase_e     phase;
	logic [3:0]              idx;
	logic                    wr_take;
	logic [7:0]              wbyte;
	logic [31:0]             next_readdata;

	logic [1:0]              q_phase;
	logic                    q_tick;

	logic [7:0]              count   [2];
	logic [7:0]              period  [2];
	pwm_pkg::timebase_ctrl_s tctrl   [2];
	logic [3:0]              presc   [2];
	logic [3:0]              post    [2];
	logic [1:0]              post_flag;
	logic [1:0]              tb_end;
	logic [9:0]              tb_fine [2];

	logic [7:0]              duty_wr [2];
	pwm_pkg::unit_ctrl_s     uctrl   [2];
	logic [7:0]              active  [2];
	logic [1:0]              tb_sel;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Two extra low bits below the count: phase at 1:1, prescaler bits otherwise
	function automatic logic [1:0] fine_bits(
		input logic [1:0] ps,
		input logic [1:0] q,
		input logic [3:0] pc
	);
		logic [1:0] r;
		if (ps == pwm_pkg::PRESCALE_DIV1) begin
			r = q;
		end else if (ps == pwm_pkg::PRESCALE_DIV4) begin
			r = pc[1:0];
		end else begin
			r = pc[3:2];
		end
		return r;
	endfunction : fine_bits

	// True on the last prescaler step of the selected ratio
	function automatic logic presc_done(
		input logic [1:0] ps,
		input logic [3:0] pc
	);
		logic r;
		if (ps == pwm_pkg::PRESCALE_DIV1) begin
			r = 1'b1;
		end else if (ps == pwm_pkg::PRESCALE_DIV4) begin
			r = pc[1:0] == pwm_pkg::PRESC_LAST4[1:0];
		end else begin
			r = pc == pwm_pkg::PRESC_LAST16;
		end
		return r;
	endfunction : presc_done

	// ----------------------------------------------------------------
	// Register bus slave
	// ----------------------------------------------------------------

	// Request decode; a write acts only on the edge where waitrequest is low
	assign idx     = avs_address[5:2];
	assign wr_take = avs_write && (phase == pwm_pkg::BUS_ANSWER);
	assign wbyte   = avs_writedata[7:0];

	// One wait cycle per access keeps the read mux out of the request path
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase           <= pwm_pkg::BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			unique case (phase)
				pwm_pkg::BUS_IDLE: begin
					if (avs_read || avs_write) begin
						phase           <= pwm_pkg::BUS_ANSWER;
						avs_waitrequest <= 1'b0;
					end
				end
				pwm_pkg::BUS_ANSWER: begin
					phase           <= pwm_pkg::BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Read mux; unmapped words and reserved bits read as zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		case (idx)
			pwm_pkg::REG_COUNT_A:   next_readdata[7:0] = count[0];
			pwm_pkg::REG_PERIOD_A:  next_readdata[7:0] = period[0];
			pwm_pkg::REG_TCTRL_A:   next_readdata[7:0] = tctrl[0];
			pwm_pkg::REG_COUNT_B:   next_readdata[7:0] = count[1];
			pwm_pkg::REG_PERIOD_B:  next_readdata[7:0] = period[1];
			pwm_pkg::REG_TCTRL_B:   next_readdata[7:0] = tctrl[1];
			pwm_pkg::REG_DUTY_U4:   next_readdata[7:0] = duty_wr[0];
			pwm_pkg::REG_ACTIVE_U4: next_readdata[7:0] = active[0];
			pwm_pkg::REG_DUTY_U5:   next_readdata[7:0] = duty_wr[1];
			pwm_pkg::REG_ACTIVE_U5: next_readdata[7:0] = active[1];
			pwm_pkg::REG_UCTRL_U4:  next_readdata[7:0] = uctrl[0];
			pwm_pkg::REG_UCTRL_U5:  next_readdata[7:0] = uctrl[1];
			pwm_pkg::REG_TB_SELECT: next_readdata[1:0] = tb_sel;
			pwm_pkg::REG_STATUS:    next_readdata[3:0] = {pwm_output_pin, post_flag};
			default:                next_readdata = 32'h0000_0000;
		endcase
	end

	// Read data is captured as waitrequest drops and stands through the answer cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (phase == pwm_pkg::BUS_IDLE && avs_read) begin
			avs_readdata <= next_readdata;
		end
	end

	// ----------------------------------------------------------------
	// Oscillator phase
	// ----------------------------------------------------------------

	// Four oscillator clocks make one instruction cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q_phase <= 2'h0;
		end else begin
			q_phase <= 2'(q_phase + 2'h1);
		end
	end

	assign q_tick = q_phase == pwm_pkg::Q_LAST;

	// ----------------------------------------------------------------
	// Timebases
	// ----------------------------------------------------------------
	for (genvar t = 0; t < 2; t++) begin : g_tb
		logic [3:0] a_count;
		logic [3:0] a_period;
		logic [3:0] a_ctrl;
		logic       w_count;
		logic       w_ctrl;
		logic       inc;
		logic       at_end;
		logic [7:0] next_count;
		logic [3:0] next_presc;

		assign a_count  = (t == 0) ? pwm_pkg::REG_COUNT_A  : pwm_pkg::REG_COUNT_B;
		assign a_period = (t == 0) ? pwm_pkg::REG_PERIOD_A : pwm_pkg::REG_PERIOD_B;
		assign a_ctrl   = (t == 0) ? pwm_pkg::REG_TCTRL_A  : pwm_pkg::REG_TCTRL_B;
		assign w_count  = wr_take && idx == a_count;
		assign w_ctrl   = wr_take && idx == a_ctrl;

		// Count step and period match
		always_comb begin
			inc    = tctrl[t].run && q_tick && presc_done(tctrl[t].prescale, presc[t]);
			at_end = inc && count[t] == period[t];
			if (w_count) begin
				next_count = wbyte;
			end else if (at_end) begin
				next_count = 8'h00;
			end else if (inc) begin
				next_count = 8'(count[t] + 8'h01);
			end else begin
				next_count = count[t];
			end
			// A count or control write restarts the prescaler
			if (w_count || w_ctrl) begin
				next_presc = 4'h0;
			end else if (tctrl[t].run && q_tick) begin
				next_presc = inc ? 4'h0 : 4'(presc[t] + 4'h1);
			end else begin
				next_presc = presc[t];
			end
		end

		// Units compare against the value the fine count takes at the coming edge,
		// so the pin moves on the same edge as the count and the high time is exact
		assign tb_fine[t] = {next_count,
			fine_bits(tctrl[t].prescale, 2'(q_phase + 2'h1), next_presc)};
		assign tb_end[t]  = at_end;

		// Count and prescaler
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				count[t] <= pwm_pkg::COUNT_RESET;
				presc[t] <= 4'h0;
			end else begin
				count[t] <= next_count;
				presc[t] <= next_presc;
			end
		end

		// Period limit and control registers
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				period[t] <= pwm_pkg::PERIOD_RESET;
				tctrl[t]  <= pwm_pkg::TCTRL_RESET;
			end else begin
				if (wr_take && idx == a_period) begin
					period[t] <= wbyte;
				end
				if (w_ctrl) begin
					tctrl[t] <= {1'b0, wbyte[6:0]};
				end
			end
		end

		// Postscaler counts period ends into its own flag only; the pins never see it
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				post[t]      <= 4'h0;
				post_flag[t] <= 1'b0;
			end else begin
				if (w_ctrl) begin
					post[t] <= 4'h0;
				end else if (at_end) begin
					post[t] <= (post[t] == tctrl[t].postscale) ? 4'h0 : 4'(post[t] + 4'h1);
				end
				// A set in the clearing cycle wins over the clear
				if (at_end && post[t] == tctrl[t].postscale) begin
					post_flag[t] <= 1'b1;
				end else if (wr_take && idx == pwm_pkg::REG_STATUS && avs_writedata[t]) begin
					post_flag[t] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Unit registers
	// ----------------------------------------------------------------

	// Timebase choice per unit: bit clear uses timebase a, set uses b
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tb_sel <= 2'h0;
		end else if (wr_take && idx == pwm_pkg::REG_TB_SELECT) begin
			tb_sel <= wbyte[1:0];
		end
	end

	for (genvar u = 0; u < 2; u++) begin : g_unit
		logic [3:0] a_duty;
		logic [3:0] a_uctrl;
		logic [3:0] a_active;

		assign a_duty   = (u == 0) ? pwm_pkg::REG_DUTY_U4   : pwm_pkg::REG_DUTY_U5;
		assign a_uctrl  = (u == 0) ? pwm_pkg::REG_UCTRL_U4  : pwm_pkg::REG_UCTRL_U5;
		assign a_active = (u == 0) ? pwm_pkg::REG_ACTIVE_U4 : pwm_pkg::REG_ACTIVE_U5;

		// Duty byte and control take writes at any moment
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				duty_wr[u] <= pwm_pkg::DUTY_RESET;
				uctrl[u]   <= pwm_pkg::UCTRL_RESET;
			end else begin
				if (wr_take && idx == a_duty) begin
					duty_wr[u] <= wbyte;
				end
				if (wr_take && idx == a_uctrl) begin
					uctrl[u] <= {2'h0, wbyte[5:0]};
				end
			end
		end

		// Duty compare and pin latch; a duty past the period never matches
		pwm_channel u_channel (
			.sys_clk          (sys_clk),
			.rst_n            (rst_n),
			.period_end       (tb_end[tb_sel[u]]),
			.next_fine        (tb_fine[tb_sel[u]]),
			.unit_control     (uctrl[u]),
			.duty_write_byte  (duty_wr[u]),
			.active_wr        (wr_take && idx == a_active),
			.wdata            (wbyte),
			.duty_active_byte (active[u]),
			.pwm_output_pin   (pwm_output_pin[u]),
			.pin_claim        (pin_claim[u])
		);
	end

endmodule : ccp_pwm_top

`default_nettype wire

// ---- pwm_pkg.sv ----
// Shared constants, register layouts and types of the PWM timebase and duty units
`default_nettype none

package pwm_pkg;

	// ----------------------------------------------------------------
	// Register word indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_COUNT_A   = 4'h0;
	localparam logic [3:0] REG_PERIOD_A  = 4'h1;
	localparam logic [3:0] REG_TCTRL_A   = 4'h2;
	localparam logic [3:0] REG_COUNT_B   = 4'h3;
	localparam logic [3:0] REG_PERIOD_B  = 4'h4;
	localparam logic [3:0] REG_TCTRL_B   = 4'h5;
	localparam logic [3:0] REG_DUTY_U4   = 4'h6;
	localparam logic [3:0] REG_ACTIVE_U4 = 4'h7;
	localparam logic [3:0] REG_DUTY_U5   = 4'h8;
	localparam logic [3:0] REG_ACTIVE_U5 = 4'h9;
	localparam logic [3:0] REG_UCTRL_U4  = 4'ha;
	localparam logic [3:0] REG_UCTRL_U5  = 4'hb;
	localparam logic [3:0] REG_TB_SELECT = 4'hc;
	localparam logic [3:0] REG_STATUS    = 4'hd;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] COUNT_RESET  = 8'h00;
	localparam logic [7:0] PERIOD_RESET = 8'hff;
	localparam logic [7:0] TCTRL_RESET  = 8'h00;
	localparam logic [7:0] DUTY_RESET   = 8'h00;
	localparam logic [7:0] UCTRL_RESET  = 8'h00;

	// ----------------------------------------------------------------
	// Timing and field codes
	// ----------------------------------------------------------------
	localparam logic [1:0] Q_LAST        = 2'h3;  // Fourth oscillator phase of a cycle
	localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
	localparam logic [1:0] PRESCALE_DIV4 = 2'h1;  // 2'h2 and 2'h3 both give 16
	localparam logic [1:0] MODE_PWM      = 2'h3;  // Upper two mode bits
	localparam logic [3:0] PRESC_LAST4   = 4'h3;
	localparam logic [3:0] PRESC_LAST16  = 4'hf;

	// Timebase control byte
	typedef struct packed {
		logic       rsvd;
		logic [3:0] postscale;
		logic       run;
		logic [1:0] prescale;
	} timebase_ctrl_s;

	// Unit control byte
	typedef struct packed {
		logic [1:0] rsvd;
		logic [1:0] duty_low;
		logic [3:0] mode;
	} unit_ctrl_s;

	// Register bus answer phase
	typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_phase_e;

endpackage : pwm_pkg

`default_nettype wire

// ---- pwm_channel.sv ----
// One duty unit: double-buffered duty value and the output pin latch
`default_nettype none

module pwm_channel (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	// Timebase view
	input  wire logic                  period_end,
	input  wire logic [9:0]            next_fine,
	// Software side
	input  wire pwm_pkg::unit_ctrl_s   unit_control,
	input  wire logic [7:0]            duty_write_byte,
	input  wire logic                  active_wr,
	input  wire logic [7:0]            wdata,
	// Results
	output logic      [7:0]            duty_active_byte,
	output logic                       pwm_output_pin,
	output logic                       pin_claim
);

	logic       pwm_on;
	logic [1:0] duty_low_latch;
	logic [9:0] next_duty;

	// Mode decode and the duty value that a period end would load
	assign pwm_on    = unit_control.mode[3:2] == pwm_pkg::MODE_PWM;
	assign next_duty = {duty_write_byte, unit_control.duty_low};

	// Active duty buffer: reloaded at period end in PWM mode and written directly only outside it, so a write never glitches the pin
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			duty_active_byte <= pwm_pkg::DUTY_RESET;
			duty_low_latch   <= 2'h0;
		end else if (pwm_on && period_end) begin
			duty_active_byte <= duty_write_byte;
			duty_low_latch   <= unit_control.duty_low;
		end else if (!pwm_on && active_wr) begin
			duty_active_byte <= wdata;
		end
	end

	// Pin latch: set at period end, cleared on the fine-count match
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_output_pin <= 1'b0;
		end else if (!pwm_on) begin
			pwm_output_pin <= 1'b0;
		end else if (period_end) begin
			pwm_output_pin <= next_duty != 10'h000;
		end else if (next_fine == {duty_active_byte, duty_low_latch}) begin
			pwm_output_pin <= 1'b0;
		end
	end

	// Pin ownership follows the mode field
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_claim <= 1'b0;
		end else begin
			pin_claim <= pwm_on;
		end
	end

endmodule : pwm_channel

`default_nettype wire

// ---- ccp_pwm_properties.sv ----
// Checker of the register slave handshake and the PWM pins
`default_nettype none
module ccp_pwm_checker (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_n,
	// Register slave
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Pins
	input wire logic [1:0]  pwm_output_pin,
	input wire logic [1:0]  pin_claim
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------
	// Steps of an access
	// ------------------------------------------------
	// Request seen by an idle slave
	sequence take_s;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	// Unit 4 control write at its completing edge
	sequence ctrl4_s;
		avs_write && !avs_waitrequest && avs_address[5:2] == pwm_pkg::REG_UCTRL_U4;
	endsequence

	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	AST_ANSWER_NEXT: assert property (take_s |=> !avs_waitrequest)
		else $error("waitrequest did not drop after a request");
	AST_ANSWER_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_NO_IDLE_ANSWER: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("answer without a request");
	AST_UPPER_ZERO: assert property (avs_readdata[31:8] == 24'h0)
		else $error("read data above the byte not zero");
	AST_UNMAPPED_ZERO: assert property (
		take_s ##0 (avs_read && avs_address[5:2] >= 4'he) |=> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	// Claim is registered from the decoded mode, so it follows two edges after the write
	AST_CLAIM_MODE: assert property (
		ctrl4_s |=> ##1 (pin_claim[0] == ($past(avs_writedata[3:2], 2) == pwm_pkg::MODE_PWM)))
		else $error("pin claim does not follow the mode field");
	AST_ZERO_CTRL_LOW: assert property (
		ctrl4_s ##0 (avs_writedata[7:0] == 8'h00) |=> ##1 (!pwm_output_pin[0]) [*4])
		else $error("pin not low after zero control write");
	AST_PIN_NEEDS_CLAIM: assert property ((pwm_output_pin & ~pin_claim & ~$past(pin_claim)) == 2'h0)
		else $error("pin high outside PWM mode");
	AST_STATUS_PINS: assert property (
		take_s ##0 (avs_read && avs_address[5:2] == pwm_pkg::REG_STATUS)
		|=> avs_readdata[3:2] == $past(pwm_output_pin))
		else $error("status pin levels wrong");
	AST_RISE_SPACING: assert property ($rose(pwm_output_pin[0]) |=> (!$rose(pwm_output_pin[0])) [*3])
		else $error("pin rose twice within the shortest period");
endmodule : ccp_pwm_checker

bind ccp_pwm_top ccp_pwm_checker chk (
	.sys_clk        (sys_clk),
	.rst_n          (rst_n),
	.avs_address    (avs_address),
	.avs_read       (avs_read),
	.avs_write      (avs_write),
	.avs_writedata  (avs_writedata),
	.avs_readdata   (avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.pwm_output_pin (pwm_output_pin),
	.pin_claim      (pin_claim)
);
`default_nettype wire

// ---- pwm_load.sv ----
// Behavioural load on one PWM pin that measures pulse widths and periods
`default_nettype none
module pwm_load (
	// Clock and reset
	input wire logic         sys_clk,
	input wire logic         rst_n,
	// Pin as the device drives it
	input wire logic         drive,
	input wire logic         claim,
	// Measurements
	output var logic [15:0]  high_len,
	output var logic [15:0]  period_len,
	output var logic [15:0]  rises
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        seen;
	logic        prev;
	logic [15:0] since;
	logic [15:0] hi;
	// Unclaimed pin falls to the pull-down, never a stale level
	assign seen = claim ? drive : 1'b0;
	// Count high samples and the distance between rising samples
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev       <= 1'b0;
			since      <= 16'h0;
			hi         <= 16'h0;
			high_len   <= 16'h0;
			period_len <= 16'h0;
			rises      <= 16'h0;
		end else begin
			prev <= seen;
			if (seen && !prev) begin
				period_len <= since;
				since      <= 16'h1;
				hi         <= 16'h1;
				rises      <= rises + 16'h1;
			end else begin
				since <= since + 16'h1;
				if (seen) begin
					hi <= hi + 16'h1;
				end
			end
			if (!seen && prev) begin
				high_len <= hi;
			end
		end
	end
endmodule : pwm_load
`default_nettype wire

// ---- ccp_pwm_mode_generator_bench.sv ----
// Self-checking bench of the PWM generator over its register slave
`default_nettype none
module ccp_pwm_mode_generator_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CEILING = 40000; // Whole run needs about 6000 cycles
	localparam logic [3:0] RIDX [6] = '{pwm_pkg::REG_PERIOD_A, pwm_pkg::REG_PERIOD_B,
		pwm_pkg::REG_COUNT_A, pwm_pkg::REG_UCTRL_U4, pwm_pkg::REG_ACTIVE_U5, 4'he};
	localparam logic [7:0] RVAL [6] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [1:0] PS [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
	localparam logic [7:0] PER [5] = '{8'h03, 8'h01, 8'h02, 8'h00, 8'h00};
	localparam logic [9:0] DUTY [5] = '{10'h005, 10'h003, 10'h007, 10'h002, 10'h003};
	logic        sys_clk = 1'b0;
	logic        rst_n;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [1:0]  pwm_output_pin;
	logic [1:0]  pin_claim;
	logic [15:0] hi_len [2];
	logic [15:0] per_len [2];
	logic [15:0] rises [2];
	logic [7:0]  rd;
	int          fail_count;
	int          checks_done;
	int          cycles = 0;

	// ------------------------------------------------
	// Design, loads and clock
	// ------------------------------------------------
	ccp_pwm_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pwm_output_pin(pwm_output_pin), .pin_claim(pin_claim));
	for (genvar u = 0; u < 2; u++) begin : g_load
		pwm_load load (.sys_clk(sys_clk), .rst_n(rst_n), .drive(pwm_output_pin[u]),
			.claim(pin_claim[u]), .high_len(hi_len[u]), .period_len(per_len[u]),
			.rises(rises[u]));
	end
	always #20 sys_clk = ~sys_clk;
	// Cut a hang short
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == CEILING) begin
			$display("[FAIL] run length expected below %0d seen %0d", CEILING, cycles);
			fail_count++;
			results();
		end
	end

	// ------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------
	// One access; request held until waitrequest is seen low, only the ceiling ends a wait
	task automatic access(input logic wr, input logic [3:0] idx, input logic [7:0] d);
		@(posedge sys_clk);
		avs_read      <= !wr;
		avs_write     <= wr;
		avs_address   <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata[7:0];
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : access
	task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk_reg
	task automatic chk_len(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %0d seen %0d", what, exp, got);
			fail_count++;
		end
	endtask : chk_len
	task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp, input logic [7:0] mask);
		access(1'b0, idx, 8'h00);
		chk_reg("register", exp, rd & mask);
	endtask : rd_chk
	// Setup in the recommended order, unit off first
	task automatic setup(input logic u, input logic [1:0] ps, input logic [7:0] per,
		input logic [9:0] duty, input logic [3:0] post);
		logic [3:0] tb;
		logic [3:0] uc;
		tb = u ? pwm_pkg::REG_COUNT_B : pwm_pkg::REG_COUNT_A;
		uc = u ? pwm_pkg::REG_UCTRL_U5 : pwm_pkg::REG_UCTRL_U4;
		access(1'b1, uc, 8'h00);
		access(1'b1, tb + 4'h1, per);
		access(1'b1, u ? pwm_pkg::REG_DUTY_U5 : pwm_pkg::REG_DUTY_U4, duty[9:2]);
		access(1'b1, tb, 8'h00);
		access(1'b1, tb + 4'h2, {1'b0, post, 1'b1, ps});
		access(1'b1, uc, {2'h0, duty[1:0], 4'hc});
	endtask : setup
	// A missing rise is caught by the run ceiling, never skipped silently
	task automatic wait_rise();
		logic [15:0] r;
		r = rises[0];
		while (rises[0] === r) begin
			@(posedge sys_clk);
		end
	endtask : wait_rise
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		int f;
		int n;
		logic [7:0] c;
		rst_n = 1'b0;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		fail_count = 0;
		checks_done = 0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		// Reset values, reserved bits, unmapped word
		for (int i = 0; i < 6; i++) begin
			rd_chk(RIDX[i], RVAL[i], 8'hff);
		end
		access(1'b1, pwm_pkg::REG_TCTRL_B, 8'hff);
		rd_chk(pwm_pkg::REG_TCTRL_B, 8'h7f, 8'hff);
		access(1'b1, 4'hf, 8'haa);
		rd_chk(4'hf, 8'h00, 8'hff);
		// Every prescale code, period and high time on unit 4
		for (int i = 0; i < 5; i++) begin
			setup(1'b0, PS[i], PER[i], DUTY[i], 4'h0);
			f = (PS[i] == 2'h0) ? 1 : (PS[i] == 2'h1) ? 4 : 16;
			n = (PER[i] + 1) * 4 * f;
			repeat (4 * n + 8) @(posedge sys_clk);
			chk_len("period", 16'(n), per_len[0]);
			chk_len("high time", 16'(DUTY[i] * f), hi_len[0]);
		end
		// Unit 5 on timebase b with the postscaler at its slowest
		access(1'b1, pwm_pkg::REG_TB_SELECT, 8'h02);
		setup(1'b1, 2'h0, 8'h01, 10'h003, 4'hf);
		repeat (40) @(posedge sys_clk);
		chk_len("period b", 16'd8, per_len[1]);
		chk_len("high time b", 16'd3, hi_len[1]);
		// Postscale 1:16 flags only on the sixteenth period end, about 128 cycles in
		rd_chk(pwm_pkg::REG_STATUS, 8'h00, 8'h02);
		repeat (100) @(posedge sys_clk);
		rd_chk(pwm_pkg::REG_STATUS, 8'h02, 8'h02);
		// Zero duty never sets the pin
		setup(1'b0, 2'h0, 8'h00, 10'h000, 4'h0);
		repeat (20) @(posedge sys_clk);
		c = rises[0][7:0];
		repeat (40) @(posedge sys_clk);
		chk_reg("rises zero duty", c, rises[0][7:0]);
		rd_chk(pwm_pkg::REG_STATUS, 8'h00, 8'h04);
		// Duty beyond the period never clears the pin
		setup(1'b0, 2'h0, 8'h00, 10'h3ff, 4'h0);
		repeat (20) @(posedge sys_clk);
		c = rises[0][7:0];
		repeat (40) @(posedge sys_clk);
		chk_reg("rises long duty", c, rises[0][7:0]);
		rd_chk(pwm_pkg::REG_STATUS, 8'h04, 8'h04);
		// Duty change mid-period waits for the period end
		setup(1'b0, 2'h0, 8'hff, 10'h101, 4'h0);
		wait_rise();
		wait_rise();
		access(1'b1, pwm_pkg::REG_DUTY_U4, 8'h80);
		access(1'b1, pwm_pkg::REG_UCTRL_U4, 8'h2c);
		rd_chk(pwm_pkg::REG_ACTIVE_U4, 8'h40, 8'hff);
		access(1'b1, pwm_pkg::REG_ACTIVE_U4, 8'h55);
		rd_chk(pwm_pkg::REG_ACTIVE_U4, 8'h40, 8'hff);
		wait_rise();
		rd_chk(pwm_pkg::REG_ACTIVE_U4, 8'h80, 8'hff);
		rd_chk(pwm_pkg::REG_DUTY_U4, 8'h80, 8'hff);
		repeat (1100) @(posedge sys_clk);
		chk_len("high time new duty", 16'd514, hi_len[0]);
		chk_len("period full", 16'd1024, per_len[0]);
		// Stopped timebase holds its count
		access(1'b1, pwm_pkg::REG_TCTRL_A, 8'h00);
		access(1'b0, pwm_pkg::REG_COUNT_A, 8'h00);
		c = rd;
		repeat (40) @(posedge sys_clk);
		rd_chk(pwm_pkg::REG_COUNT_A, c, 8'hff);
		results();
	end
endmodule : ccp_pwm_mode_generator_bench
`default_nettype wire
